// ---- core/spc_pkg.sv ----
// Constants and carrier types for the serial EEPROM protocol controller.
// Assumes one system clock domain plus the serial link clock of the master.
package spc_pkg;

	// Instruction codes, first byte of every command
	localparam logic [7:0] LATCH_SET_OP    = 8'h06;
	localparam logic [7:0] LATCH_CLEAR_OP  = 8'h04;
	localparam logic [7:0] STATUS_READ_OP  = 8'h05;
	localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
	localparam logic [7:0] ARRAY_READ_OP   = 8'h03;
	localparam logic [7:0] ARRAY_WRITE_OP  = 8'h02;
	localparam logic [7:0] IDPAGE_READ_OP  = 8'h83;
	localparam logic [7:0] IDPAGE_WRITE_OP = 8'h82;

	// Status byte field positions
	localparam int ST_LOCK   = 7;
	localparam int ST_BP_HI  = 3;
	localparam int ST_BP_LO  = 2;
	localparam int ST_PERMIT = 1;
	localparam int ST_BUSY   = 0;

	// Addressing
	localparam logic [15:0] ID_ADDR_MASK   = 16'h007f;
	localparam logic [15:0] IDLOCK_ADDR    = 16'h0400;
	localparam logic [15:0] PROT_QUARTER   = 16'hc000;
	localparam logic [15:0] PROT_HALF      = 16'h8000;
	localparam logic [15:0] PROT_WHOLE     = 16'h0000;

	// Reset values of the volatile status bits
	localparam logic RST_PERMIT = 1'b0;
	localparam logic RST_BUSY   = 1'b0;

	// Length of the self-timed write cycle in system clocks
	localparam int WR_CYCLES_DEF = 1000;

	// Command phase, Gray coded along opcode, address, data
	typedef enum logic [2:0] {
		PH_OPC     = 3'b000,
		PH_ADDR_HI = 3'b001,
		PH_ADDR_LO = 3'b011,
		PH_DATA    = 3'b010,
		PH_READ    = 3'b110,
		PH_WAIT    = 3'b111
	} spc_phase_e;

	typedef enum logic [2:0] {
		WK_NONE   = 3'b000,
		WK_STATUS = 3'b001,
		WK_ARRAY  = 3'b011,
		WK_IDPAGE = 3'b010,
		WK_FREEZE = 3'b110
	} spc_wkind_e;

	// Non-volatile bits, kept by the array outside across power cycles
	typedef struct packed {
		logic       idlock;
		logic       lock;
		logic [1:0] bp;
	} spc_nv_s;

	// Write cycle launched towards the array
	typedef struct packed {
		logic        valid;
		spc_wkind_e  kind;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [7:0]  count;
	} spc_launch_s;

endpackage

// ---- core/spc_ctrl.sv ----
// Serial slave protocol control of a byte-wide EEPROM: frame qualification,
// pause, opcode and address decode, permit latch, protection, write cycle.
// Assumes the master leaves at least four system clocks between a chip
// select rise and its next serial clock edge, and that rd_data follows
// rd_addr combinationally within half a serial clock period.
`timescale 1ns/1ps
module spc_ctrl #(
	parameter int WR_CYCLES = spc_pkg::WR_CYCLES_DEF
) (
	// System clock and power-on reset
	input  wire logic                clock,
	input  wire logic                arst_n,
	// Serial link pins
	input  wire logic                sck,
	input  wire logic                cs_n,
	input  wire logic                mosi,
	input  wire logic                hold_n,
	input  wire logic                wp_n,
	output logic                     miso,
	output logic                     miso_oe,
	// Array read side, link clock domain
	output logic [15:0]              rd_addr,
	output logic                     rd_idpage,
	input  wire logic [7:0]          rd_data,
	// Array write side and stored bits, system clock domain
	input  wire spc_pkg::spc_nv_s    nv_restore,
	output spc_pkg::spc_nv_s         nv_state,
	output spc_pkg::spc_launch_s     launch,
	output logic [7:0]               status,
	output logic                     selected,
	output logic                     standby
);

	localparam int CW = $clog2(WR_CYCLES + 1);

	typedef struct packed {
		logic                 cs_s1;
		logic                 cs_s2;
		logic                 cs_s3;
		logic                 wp_s1;
		logic                 wp_s2;
		logic                 ok_s1;
		logic                 ok_s2;
		logic                 ftog_seen;
		logic                 booted;
		logic                 permit;
		logic                 busy;
		logic [CW-1:0]        cnt;
		spc_pkg::spc_wkind_e  pend;
		logic [7:0]           pend_data;
		spc_pkg::spc_nv_s     nv;
		spc_pkg::spc_launch_s launch;
		logic [7:0]           stat;
		logic                 selected;
		logic                 standby;
	} spc_sys_s;

	typedef struct packed {
		logic                 ftog;
		spc_pkg::spc_phase_e  phase;
		logic [2:0]           bitcnt;
		logic [7:0]           shreg;
		logic [7:0]           op;
		logic [15:0]          addr;
		logic [7:0]           nbytes;
		logic [7:0]           data;
		logic [8:0]           st1;
		logic [8:0]           st2;
	} spc_link_s;

	typedef struct packed {
		logic miso;
		logic oe;
	} spc_tx_s;

	spc_sys_s  sq;
	spc_sys_s  sd;
	spc_link_s lq;
	spc_link_s ld;
	spc_tx_s   tq;
	spc_tx_s   td;
	logic      sel_ok;
	logic      fresh;
	logic      tx_rst;

	function automatic logic prot_hit(input logic [1:0] bp, input logic [15:0] a);
		unique case (bp)
			2'b00:   prot_hit = 1'b0;
			2'b01:   prot_hit = a >= spc_pkg::PROT_QUARTER;
			2'b10:   prot_hit = a >= spc_pkg::PROT_HALF;
			2'b11:   prot_hit = a >= spc_pkg::PROT_WHOLE;
		endcase
	endfunction

	function automatic logic is_lock_addr(input logic [7:0] op, input logic [15:0] a);
		is_lock_addr = (op[7] == 1'b1) && (a == spc_pkg::IDLOCK_ADDR);
	endfunction

	// Frame qualification: only a chip select fall after reset opens frames
	always_ff @(negedge cs_n or negedge arst_n) begin
		if (!arst_n) begin
			sel_ok <= 1'b0;
		end else begin
			sel_ok <= 1'b1;
		end
	end

	// Marks a frame with no serial edge yet; chip select high restarts it
	always_ff @(posedge sck or posedge cs_n or negedge arst_n) begin
		if (!arst_n) begin
			fresh <= 1'b1;
		end else if (cs_n) begin
			fresh <= 1'b1;
		end else if (hold_n && sel_ok) begin
			fresh <= 1'b0;
		end
	end

	// Link receive side, rising serial clock
	always_comb begin
		logic [2:0]          bc;
		logic [7:0]          nb;
		logic [7:0]          rx;
		spc_pkg::spc_phase_e ph;
		bc = 3'h0;
		nb = 8'h00;
		rx = 8'h00;
		ph = spc_pkg::PH_OPC;
		ld = lq;
		ld.st1 = {sq.nv.idlock, sq.stat};
		ld.st2 = lq.st1;
		// Paused edges and edges before the first select fall change only the status copies st1 and st2
		if (hold_n && sel_ok) begin
			bc = fresh ? 3'h0 : lq.bitcnt;
			nb = fresh ? 8'h00 : lq.nbytes;
			ph = fresh ? spc_pkg::PH_OPC : lq.phase;
			rx = {lq.shreg[6:0], mosi};
			if (fresh) begin
				ld.ftog = ~lq.ftog;
			end
			ld.shreg = rx;
			ld.bitcnt = bc + 3'h1;
			ld.nbytes = nb;
			ld.phase = ph;
			if (bc == 3'h7) begin
				if (nb != 8'hff) begin
					ld.nbytes = nb + 8'h01;
				end
				unique case (ph)
					spc_pkg::PH_OPC: begin
						ld.op = rx;
						unique case (rx)
							spc_pkg::STATUS_READ_OP:  ld.phase = spc_pkg::PH_READ;
							spc_pkg::STATUS_WRITE_OP: ld.phase = spc_pkg::PH_DATA;
							spc_pkg::ARRAY_READ_OP,
							spc_pkg::ARRAY_WRITE_OP,
							spc_pkg::IDPAGE_READ_OP,
							spc_pkg::IDPAGE_WRITE_OP: ld.phase = spc_pkg::PH_ADDR_HI;
							default:                  ld.phase = spc_pkg::PH_WAIT;
						endcase
					end
					spc_pkg::PH_ADDR_HI: begin
						ld.addr = {rx, lq.addr[7:0]};
						ld.phase = spc_pkg::PH_ADDR_LO;
					end
					spc_pkg::PH_ADDR_LO: begin
						ld.addr = {lq.addr[15:8], rx};
						// Id page keeps only its low seven bits, except the lock address
						if (lq.op[7] && !is_lock_addr(lq.op, {lq.addr[15:8], rx})) begin
							ld.addr = {lq.addr[15:8], rx} & spc_pkg::ID_ADDR_MASK;
						end
						ld.phase = lq.op[0] ? spc_pkg::PH_READ : spc_pkg::PH_DATA;
					end
					spc_pkg::PH_DATA: begin
						ld.data = rx;
					end
					spc_pkg::PH_READ: begin
						if (lq.op == spc_pkg::IDPAGE_READ_OP) begin
							if (!is_lock_addr(lq.op, lq.addr)) begin
								ld.addr = (lq.addr + 16'h0001) & spc_pkg::ID_ADDR_MASK;
							end
						end else if (lq.op == spc_pkg::ARRAY_READ_OP) begin
							ld.addr = lq.addr + 16'h0001;
						end
					end
					spc_pkg::PH_WAIT: begin
						ld.phase = spc_pkg::PH_WAIT;
					end
				endcase
			end
		end
	end

	// Link state survives select rises so the system side can judge the frame
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	// Link transmit side, falling serial clock
	always_comb begin
		logic [2:0] idx;
		idx = ~lq.bitcnt;
		td.miso = 1'b0;
		if (lq.op == spc_pkg::STATUS_READ_OP) begin
			td.miso = lq.st2[idx];
		end else if (is_lock_addr(lq.op, lq.addr)) begin
			td.miso = (idx == 3'h0) ? lq.st2[8] : 1'b0;
		end else begin
			td.miso = rd_data[idx];
		end
		td.oe = (lq.phase == spc_pkg::PH_READ) && hold_n && sel_ok && !fresh;
	end

	assign tx_rst = cs_n | ~arst_n;

	// Output floats from the select rise; pause floats it at the next fall
	always_ff @(negedge sck or posedge tx_rst) begin
		if (tx_rst) begin
			tq <= '0;
		end else begin
			tq <= td;
		end
	end

	// System side: select qualification, command execution, write cycle
	always_comb begin
		logic end_frame;
		logic hpm;
		logic start;
		spc_pkg::spc_wkind_e kind;
		end_frame = 1'b0;
		hpm = 1'b0;
		start = 1'b0;
		kind = spc_pkg::WK_NONE;
		sd = sq;
		sd.cs_s1 = cs_n;
		sd.cs_s2 = sq.cs_s1;
		sd.cs_s3 = sq.cs_s2;
		sd.wp_s1 = wp_n;
		sd.wp_s2 = sq.wp_s1;
		sd.ok_s1 = sel_ok;
		sd.ok_s2 = sq.ok_s1;
		sd.booted = 1'b1;
		sd.launch.valid = 1'b0;
		// Stored bits come back from the array once, after reset release
		if (!sq.booted) begin
			sd.nv = nv_restore;
		end
		// Link fields are quiet here: the serial clock has stopped
		if (sq.cs_s2 && !sq.cs_s3) begin
			sd.ftog_seen = lq.ftog;
			end_frame = lq.ftog != sq.ftog_seen;
		end
		hpm = sq.nv.lock && !sq.wp_s2;
		if (end_frame && lq.bitcnt == 3'h0 && !sq.busy) begin
			unique case (lq.op)
				spc_pkg::LATCH_SET_OP: begin
					if (lq.nbytes == 8'h01) begin
						sd.permit = 1'b1;
					end
				end
				spc_pkg::LATCH_CLEAR_OP: begin
					if (lq.nbytes == 8'h01) begin
						sd.permit = 1'b0;
					end
				end
				spc_pkg::STATUS_WRITE_OP: begin
					start = lq.nbytes == 8'h02 && sq.permit && !hpm;
					kind = spc_pkg::WK_STATUS;
				end
				spc_pkg::ARRAY_WRITE_OP: begin
					start = lq.nbytes >= 8'h04 && sq.permit && !prot_hit(sq.nv.bp, lq.addr);
					kind = spc_pkg::WK_ARRAY;
				end
				spc_pkg::IDPAGE_WRITE_OP: begin
					start = lq.nbytes >= 8'h04 && sq.permit && !sq.nv.idlock;
					kind = is_lock_addr(lq.op, lq.addr) ? spc_pkg::WK_FREEZE : spc_pkg::WK_IDPAGE;
				end
				default: begin
					start = 1'b0;
				end
			endcase
		end
		if (start) begin
			sd.busy = 1'b1;
			sd.cnt = CW'(WR_CYCLES);
			sd.pend = kind;
			sd.pend_data = lq.data;
			sd.launch = '{valid: 1'b1, kind: kind, addr: lq.addr, data: lq.data,
				count: lq.nbytes - ((kind == spc_pkg::WK_STATUS) ? 8'h01 : 8'h03)};
		end else if (sq.busy) begin
			sd.cnt = sq.cnt - CW'(1);
			if (sq.cnt == CW'(1)) begin
				sd.busy = 1'b0;
				sd.permit = 1'b0;
				if (sq.pend == spc_pkg::WK_STATUS) begin
					sd.nv.lock = sq.pend_data[spc_pkg::ST_LOCK];
					sd.nv.bp = {sq.pend_data[spc_pkg::ST_BP_HI], sq.pend_data[spc_pkg::ST_BP_LO]};
				end else if (sq.pend == spc_pkg::WK_FREEZE) begin
					sd.nv.idlock = 1'b1;
				end
			end
		end
		sd.stat = {sq.nv.lock, 3'h0, sq.nv.bp, sq.permit, sq.busy};
		sd.selected = !sq.cs_s2 && sq.ok_s2;
		sd.standby = sq.cs_s2 && !sq.busy;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sq <= '0;
			sq.cs_s1 <= 1'b1;
			sq.cs_s2 <= 1'b1;
			sq.cs_s3 <= 1'b1;
			sq.permit <= spc_pkg::RST_PERMIT;
			sq.busy <= spc_pkg::RST_BUSY;
			sq.standby <= 1'b1;
		end else begin
			sq <= sd;
		end
	end

	assign miso = tq.miso;
	assign miso_oe = tq.oe;
	assign rd_addr = lq.addr;
	assign rd_idpage = lq.op[7];
	assign nv_state = sq.nv;
	assign launch = sq.launch;
	assign status = sq.stat;
	assign selected = sq.selected;
	assign standby = sq.standby;

	powerup_state_a: assert property (@(posedge clock) disable iff (!arst_n)
		!sq.booted |-> !sq.permit && !sq.busy && sq.standby && !sq.selected)
		else $error("state after power-on is wrong");

	select_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.selected |-> $past(sel_ok, 3) && !$past(cs_n, 3))
		else $error("selected without qualified select fall");

	standby_busy_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.busy && sq.cs_s2 |=> !sq.standby)
		else $error("standby entered during write cycle");

	write_len_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(sq.busy) |-> sq.cnt == CW'(WR_CYCLES) && sq.launch.valid)
		else $error("write cycle started with wrong length");

	write_end_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.busy && sq.cnt == CW'(1) |=> !sq.busy && !sq.permit)
		else $error("write cycle end left busy or permit set");

	status_guard_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.launch.valid && sq.launch.kind == spc_pkg::WK_STATUS
			|-> $past(sq.permit) && !$past(sq.nv.lock && !sq.wp_s2))
		else $error("status write accepted while guarded");

	array_guard_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.launch.valid && sq.launch.kind == spc_pkg::WK_ARRAY
			|-> !prot_hit($past(sq.nv.bp), sq.launch.addr) && $past(sq.permit))
		else $error("array write launched into protected area");

	whole_bytes_a: assert property (@(posedge clock) disable iff (!arst_n)
		sq.launch.valid |-> lq.bitcnt == 3'h0)
		else $error("write launched on partial byte");

	pause_hold_a: assert property (@(posedge sck) disable iff (!arst_n || cs_n)
		!hold_n && !fresh |=> $stable(lq.bitcnt) && $stable(lq.shreg) && $stable(lq.phase))
		else $error("shift position moved during pause");

endmodule

// ---- test/spc_master.sv ----
// Serial bus master model driving the link pins of the protocol controller.
// Assumes mode 0: the serial clock idles low and only toggles inside frames.
`timescale 1ns/1ps
module spc_master (
	// Link pins
	output logic      sck,
	output logic      cs_n,
	output logic      mosi,
	output logic      hold_n,
	input  wire logic miso
);
	// Held low through reset so the bench can see a level select ignored
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		mosi = 1'b0;
		hold_n = 1'b1;
	end

	// One frame of n bits taken from the top of w; pause before bit h
	task automatic frame(input logic [31:0] w, input int n, input int h,
			output logic [7:0] rx);
		rx = 8'h00;
		cs_n = 1'b0;
		#10;
		for (int i = 0; i < n; i++) begin
			if (i == h) begin
				// Garbage clocks and data while paused must leave no trace
				hold_n = 1'b0;
				repeat (3) begin
					#6 mosi = ~mosi;
					sck = 1'b1;
					#6 sck = 1'b0;
				end
				#3 hold_n = 1'b1;
			end
			#3 mosi = w[31 - i];
			#3 sck = 1'b1;
			rx = {rx[6:0], miso};
			#6 sck = 1'b0;
		end
		#3 cs_n = 1'b1;
		// Released data line shows no stale value
		mosi = ~mosi;
		#40;
	endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench: a behavioural model of the permit latch, status and
// protection is compared with the controller after every frame sent by run.
// Assumes the array outside answers rd_addr combinationally.
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic arst_n = 1'b1;
	logic wp_n = 1'b1;
	logic [7:0] rd_data;
	logic [7:0] rx;
	logic [31:0] seed = 32'd79350;
	spc_pkg::spc_nv_s nv_restore;
	spc_pkg::spc_nv_s nv_state;
	spc_pkg::spc_launch_s launch;
	spc_pkg::spc_launch_s lq[$];
	wire sck, cs_n, mosi, hold_n, miso, miso_oe, rd_idpage, selected, standby;
	wire miso_pin;
	wire [15:0] rd_addr;
	wire [7:0] status;
	int bad_count = 0;
	int tests_run = 0;
	int permit = 0;
	int lock = 0;
	int bp = 0;
	int idl = 0;

	always #4 clock = ~clock;
	assign rd_data = rd_addr[7:0] ^ 8'h5a;
	// Pulled-up data line: a missing output enable reads as ones
	assign miso_pin = miso_oe ? miso : 1'b1;
	always @(posedge clock) if (launch.valid === 1'b1) lq.push_back(launch);

	spc_ctrl #(.WR_CYCLES(20)) dut_u (.clock, .arst_n, .sck, .cs_n, .mosi, .hold_n,
		.wp_n, .miso, .miso_oe, .rd_addr, .rd_idpage, .rd_data, .nv_restore,
		.nv_state, .launch, .status, .selected, .standby);
	spc_master m_u (.sck, .cs_n, .mosi, .hold_n, .miso(miso_pin));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Send a frame, predict its effect, then compare launch and status
	task automatic run(input logic [31:0] w, input int n, input int h = 99);
		logic [15:0] a;
		logic [7:0] d;
		int kind;
		a = w[23:8];
		kind = 0;
		if (w[31:24] == spc_pkg::STATUS_WRITE_OP && n == 16 && permit != 0 &&
				!(lock != 0 && wp_n == 1'b0))
			kind = 1;
		if (w[31:24] == spc_pkg::ARRAY_WRITE_OP && n == 32 && permit != 0 &&
				!(bp == 3 || (bp == 2 && a >= 16'h8000) || (bp == 1 && a >= 16'hc000)))
			kind = 3;
		if (w[31:24] == spc_pkg::IDPAGE_WRITE_OP && n == 32 && permit != 0 && idl == 0)
			kind = (a == 16'h0400) ? 6 : 2;
		if (kind == 2)
			a = a & 16'h007f;
		d = (kind == 1) ? w[23:16] : w[7:0];
		m_u.frame(w, n, h, rx);
		repeat (10) @(posedge clock);
		#1;
		if (kind != 0) chk({status[0], standby}, 2'b10);
		repeat (30) @(posedge clock);
		#1;
		if (w[31:24] == spc_pkg::LATCH_SET_OP && n == 8) permit = 1;
		if (w[31:24] == spc_pkg::LATCH_CLEAR_OP && n == 8) permit = 0;
		chk(lq.size(), kind != 0);
		if (kind != 0 && lq.size() == 1) begin
			chk({lq[0].kind, lq[0].data, lq[0].count}, {3'(kind), d, 8'h01});
			if (kind >= 2) chk(lq[0].addr, a);
			permit = 0;
			if (kind == 6) idl = 1;
			if (kind == 1) begin
				lock = w[23];
				bp = w[19:18];
			end
		end
		lq.delete();
		chk(status, {lock[0], 3'b0, bp[1:0], permit[0], 1'b0});
		chk(nv_state, {idl[0], lock[0], bp[1:0]});
		chk(standby, 1'b1);
	endtask

	initial begin
		nv_restore = {2'b00, seed[1:0]};
		bp = seed[1:0];
		// A real edge on the reset pin, so the link flops start known too
		#1 arst_n = 1'b0;
		repeat (12) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge clock);
		#1 chk(selected, 1'b0);
		m_u.cs_n = 1'b1;
		repeat (8) @(posedge clock);
		#1 chk({standby, selected}, 2'b10);
		chk(status, {4'h0, bp[1:0], 2'b00});
		seed = lfsr(seed);
		run(32'h06000000, 8);
		run({8'h02, seed[23:0]}, 31);
		run(32'h01000000, 16);
		run(32'h01000000, 16);
		// Every protect setting, with one write just below the quarter
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			run(32'h06000000, 8);
			run({8'h01, 4'h0, i[1:0], 2'b00, 16'h0000}, 16);
			run(32'h06000000, 8);
			run({8'h02, (i == 1) ? 16'hbfff : seed[23:8], seed[7:0]}, 32);
		end
		run(32'h06000000, 8, 3);
		run(32'h04000000, 8);
		run(32'hff060000, 16);
		run(32'h06000000, 8);
		run(32'h01880000, 16);
		@(posedge clock);
		#1 wp_n = 1'b0;
		run(32'h06000000, 8);
		m_u.frame(32'h05000000, 16, 99, rx);
		chk(rx, 8'h8a);
		run(32'h018c0000, 16);
		@(posedge clock);
		#1 wp_n = 1'b1;
		run(32'h01000000, 16);
		seed = lfsr(seed);
		m_u.frame({8'h03, seed[23:8], 8'h00}, 32, 99, rx);
		chk(rx, seed[15:8] ^ 8'h5a);
		chk(rd_idpage, 1'b0);
		// Id page: upper address bits dropped, then lock query and freeze
		run(32'h06000000, 8);
		run(32'h82008533, 32);
		m_u.frame(32'h83008500, 32, 99, rx);
		chk(rx, 8'h5f);
		chk(rd_idpage, 1'b1);
		m_u.frame(32'h83040000, 32, 99, rx);
		chk(rx, 8'h00);
		run(32'h06000000, 8);
		run(32'h82040000, 32);
		m_u.frame(32'h83040000, 32, 99, rx);
		chk(rx, 8'h01);
		run(32'h06000000, 8);
		run(32'h82001100, 32);
		chk(standby, 1'b1);
		results;
	end

	initial begin
		#100000;
		bad_count++;
		results;
	end
endmodule
